// *** pkg/erx_pkg.sv ***
// Purpose: constants for the exception entry/return unit
// Assumes: 32-bit machine state, save bits 16:31 held in the low half
// Notes: register port addresses and vector offsets live here
// Contract
// - let executing instructions finish before the hardware context switch
// - on entry save next address and state bits 16:31, then modify state
// - after saving, redirect fetch to the taken exception's vector
// - every exception, debug too, overwrites both save registers
// - any write to the recoverable-set register sets the recoverable flag
// - recoverable flag at entry is captured; zero means not recoverable
// - masked breakpoints are taken only while the recoverable flag is set
// - non-masked breakpoints are taken at any time
// - vector register gives code of highest-priority pending source
// - levels above 7 report via level 7; pending bit 0 is highest
// - return reloads machine state from the second save register
// - return continues fetching at the first save register's address
// - indirect branch targets come from count or link; link form saves next
// - special registers move only through a general register, never to memory
// - taking an exception disables external interrupts until re-enabled
// - any write to the enable-set register sets enable and recoverable
// - lower level number wins when levels compete
package erx_pkg;
  localparam logic [3:0] ADR_SAVE_RET = 4'h0;
  localparam logic [3:0] ADR_SAVE_MS = 4'h1;
  localparam logic [3:0] ADR_MSR = 4'h2;
  localparam logic [3:0] ADR_RSET = 4'h3;
  localparam logic [3:0] ADR_ERSET = 4'h4;
  localparam logic [3:0] ADR_IVEC = 4'h5;
  localparam logic [3:0] ADR_PEND = 4'h6;
  localparam logic [3:0] ADR_LMASK = 4'h7;
  localparam logic [3:0] ADR_CTR = 4'h8;
  localparam logic [3:0] ADR_LR = 4'h9;
  localparam logic [3:0] ADR_DBG = 4'hA;
  localparam int MSR_EE = 15;
  localparam int MSR_FP = 13;
  localparam int MSR_RI = 1;
  localparam logic [31:0] MSR_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [31:0] VEC_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_EXT = 32'h0000_0040;
  localparam logic [31:0] VEC_DBG = 32'h0000_0080;
  localparam int NLVL = 16;
  localparam int MAIN_LVL = 7;
  localparam int NMAIN = 8;
  localparam int PEND_TOP = 31;
  localparam logic [7:0] CODE_NONE = 8'hFF;
  localparam logic [15:0] LMASK_RST = 16'h0000;
  typedef enum logic {ERX_RUN, ERX_DRAIN} erx_state_t;
endpackage : erx_pkg

// *** src/erx_exc_unit.sv ***
// Purpose: exception entry, return, branch targets and interrupt encoding
// Assumes: requests and breakpoints come from logic on the same clock
// Notes: special registers are reached only over the register port
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module erx_exc_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // pipeline
  input wire logic busy_in,
  input wire logic [31:0] next_pc_in,
  input wire logic sync_exc_in,
  input wire logic [31:0] sync_vec_in,
  input wire logic rfi_in,
  input wire logic ibr_in,
  input wire logic ibr_ctr_in,
  input wire logic ibr_link_in,
  output logic redirect_out,
  output logic [31:0] redirect_addr_out,
  output logic taken_out,
  output logic [31:0] msr_out,
  // debug and interrupt sources
  input wire logic bp_in,
  input wire logic [15:0] lvl_req_in
);

  typedef struct packed {
    erx_pkg::erx_state_t st;
    logic [31:0] save_return_address;
    logic [31:0] save_machine_state;
    logic [31:0] machine_state_reg;
    logic [31:0] ctr;
    logic [31:0] lr;
    logic [15:0] lmask;
    logic dbgnm;
    logic [31:0] cause;
    logic [31:0] rdata;
    logic redir;
    logic [31:0] raddr;
    logic taken;
  } erx_regs_t;

  erx_regs_t s;
  erx_regs_t next_s;

  // lowest set index wins; returns CODE_NONE when empty
  function automatic logic [7:0] erx_first(input logic [7:0] v);
    logic [7:0] r;
    r = erx_pkg::CODE_NONE;
    for (int i = erx_pkg::NMAIN - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction : erx_first

  logic [15:0] masked;
  logic [7:0] main_lvl;
  logic [7:0] code;
  logic [31:0] pend;
  logic ext_pend;
  logic dbg_hit;
  logic recog;

  always_comb begin
    masked = lvl_req_in & s.lmask;
    for (int i = 0; i < erx_pkg::MAIN_LVL; i++) begin
      main_lvl[i] = masked[i];
    end
    main_lvl[erx_pkg::MAIN_LVL] = |masked[erx_pkg::NLVL-1:erx_pkg::MAIN_LVL];
    code = erx_first(main_lvl);
    pend = erx_pkg::ZERO32;
    for (int l = erx_pkg::MAIN_LVL; l < erx_pkg::NLVL; l++) begin
      pend[erx_pkg::PEND_TOP - l] = masked[l];
    end
    ext_pend = (code != erx_pkg::CODE_NONE) && s.machine_state_reg[erx_pkg::MSR_EE];
    dbg_hit = bp_in && (s.dbgnm || s.machine_state_reg[erx_pkg::MSR_RI]);
    recog = (s.st == erx_pkg::ERX_RUN) && (dbg_hit || sync_exc_in || ext_pend);
  end

  always_comb begin
    next_s = s;
    next_s.redir = 1'b0;
    next_s.taken = 1'b0;
    next_s.rdata = erx_pkg::ZERO32;
    // special registers move only through general-register traffic here
    if (reg_rd_in) begin
      case (reg_addr_in)
        erx_pkg::ADR_SAVE_RET: next_s.rdata = s.save_return_address;
        erx_pkg::ADR_SAVE_MS: next_s.rdata = s.save_machine_state;
        erx_pkg::ADR_MSR: next_s.rdata = s.machine_state_reg;
        erx_pkg::ADR_IVEC: next_s.rdata = {24'h00_0000, code};
        erx_pkg::ADR_PEND: next_s.rdata = pend;
        erx_pkg::ADR_LMASK: next_s.rdata = {erx_pkg::ZERO16, s.lmask};
        erx_pkg::ADR_CTR: next_s.rdata = s.ctr;
        erx_pkg::ADR_LR: next_s.rdata = s.lr;
        erx_pkg::ADR_DBG: next_s.rdata = {31'h0000_0000, s.dbgnm};
        default: next_s.rdata = erx_pkg::ZERO32;
      endcase
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        erx_pkg::ADR_SAVE_RET: next_s.save_return_address = reg_wdata_in;
        erx_pkg::ADR_SAVE_MS: next_s.save_machine_state = reg_wdata_in;
        erx_pkg::ADR_MSR: next_s.machine_state_reg = reg_wdata_in;
        erx_pkg::ADR_RSET: next_s.machine_state_reg[erx_pkg::MSR_RI] = 1'b1;
        erx_pkg::ADR_ERSET: begin
          next_s.machine_state_reg[erx_pkg::MSR_RI] = 1'b1;
          next_s.machine_state_reg[erx_pkg::MSR_EE] = 1'b1;
        end
        erx_pkg::ADR_LMASK: next_s.lmask = reg_wdata_in[15:0];
        erx_pkg::ADR_CTR: next_s.ctr = reg_wdata_in;
        erx_pkg::ADR_LR: next_s.lr = reg_wdata_in;
        erx_pkg::ADR_DBG: next_s.dbgnm = reg_wdata_in[0];
        default: next_s.dbgnm = s.dbgnm;
      endcase
    end
    // indirect branch reads the old link value even when it also links
    if (ibr_in) begin
      next_s.redir = 1'b1;
      next_s.raddr = ibr_ctr_in ? s.ctr : s.lr;
      if (ibr_link_in) begin
        next_s.lr = next_pc_in;
      end
    end
    case (s.st)
      erx_pkg::ERX_RUN: begin
        // a return in the recognising cycle is dropped; the pipeline retries it
        if (recog) begin
          next_s.st = erx_pkg::ERX_DRAIN;
          if (dbg_hit) begin
            next_s.cause = erx_pkg::VEC_DBG;
          end else if (sync_exc_in) begin
            next_s.cause = sync_vec_in;
          end else begin
            next_s.cause = erx_pkg::VEC_EXT;
          end
        end else if (rfi_in) begin
          next_s.machine_state_reg = {s.machine_state_reg[31:16], s.save_machine_state[15:0]};
          next_s.redir = 1'b1;
          next_s.raddr = s.save_return_address;
        end
      end
      erx_pkg::ERX_DRAIN: begin
        if (!busy_in) begin
          next_s.save_return_address = next_pc_in;
          next_s.save_machine_state = {erx_pkg::ZERO16, s.machine_state_reg[15:0]};
          next_s.machine_state_reg[erx_pkg::MSR_EE] = 1'b0;
          next_s.machine_state_reg[erx_pkg::MSR_RI] = 1'b0;
          next_s.machine_state_reg[erx_pkg::MSR_FP] = 1'b0;
          next_s.redir = 1'b1;
          next_s.raddr = erx_pkg::VEC_BASE + s.cause;
          next_s.taken = 1'b1;
          next_s.st = erx_pkg::ERX_RUN;
        end
      end
      default: next_s.st = erx_pkg::ERX_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '{st: erx_pkg::ERX_RUN, save_return_address: erx_pkg::ZERO32, save_machine_state: erx_pkg::ZERO32,
             machine_state_reg: erx_pkg::MSR_RST, ctr: erx_pkg::ZERO32, lr: erx_pkg::ZERO32,
             lmask: erx_pkg::LMASK_RST, dbgnm: 1'b0, cause: erx_pkg::ZERO32,
             rdata: erx_pkg::ZERO32, redir: 1'b0, raddr: erx_pkg::ZERO32,
             taken: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign redirect_out = s.redir;
  assign redirect_addr_out = s.raddr;
  assign taken_out = s.taken;
  assign msr_out = s.machine_state_reg;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_drain_wait;
    (s.st == erx_pkg::ERX_DRAIN && busy_in) |=> !s.taken;
  endproperty
  a_drain_wait: assert property (p_drain_wait) else $error("entry during busy");

  property p_save;
    (s.st == erx_pkg::ERX_DRAIN && !busy_in) |=>
      (s.save_return_address == $past(next_pc_in)) && (s.save_machine_state[15:0] == $past(s.machine_state_reg[15:0]));
  endproperty
  a_save: assert property (p_save) else $error("save registers wrong");

  property p_vector;
    (s.st == erx_pkg::ERX_DRAIN && !busy_in) |=>
      s.redir && s.taken && (s.raddr == erx_pkg::VEC_BASE + $past(s.cause));
  endproperty
  a_vector: assert property (p_vector) else $error("vector redirect wrong");

  property p_rset;
    (reg_wr_in && reg_addr_in == erx_pkg::ADR_RSET &&
     !(s.st == erx_pkg::ERX_DRAIN && !busy_in)) |=> s.machine_state_reg[erx_pkg::MSR_RI];
  endproperty
  a_rset: assert property (p_rset) else $error("recoverable not set");

  property p_erset;
    (reg_wr_in && reg_addr_in == erx_pkg::ADR_ERSET &&
     !(s.st == erx_pkg::ERX_DRAIN && !busy_in)) |=>
      s.machine_state_reg[erx_pkg::MSR_RI] && s.machine_state_reg[erx_pkg::MSR_EE];
  endproperty
  a_erset: assert property (p_erset) else $error("enable set failed");

  property p_masked_bp;
    (s.st == erx_pkg::ERX_RUN && bp_in && !s.dbgnm && !s.machine_state_reg[erx_pkg::MSR_RI]
     && !sync_exc_in && !ext_pend) |=> s.st == erx_pkg::ERX_RUN;
  endproperty
  a_masked_bp: assert property (p_masked_bp) else $error("masked bp taken");

  property p_nonmask_bp;
    (s.st == erx_pkg::ERX_RUN && bp_in && s.dbgnm) |=>
      s.st == erx_pkg::ERX_DRAIN ##0 s.cause == erx_pkg::VEC_DBG;
  endproperty
  a_nonmask_bp: assert property (p_nonmask_bp) else $error("bp not taken");

  property p_return;
    (s.st == erx_pkg::ERX_RUN && rfi_in && !recog) |=>
      (s.machine_state_reg[15:0] == $past(s.save_machine_state[15:0])) && s.redir && (s.raddr == $past(s.save_return_address));
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  property p_ee_off;
    s.taken |-> !s.machine_state_reg[erx_pkg::MSR_EE] && !s.machine_state_reg[erx_pkg::MSR_RI];
  endproperty
  a_ee_off: assert property (p_ee_off) else $error("enable left on");

  property p_link;
    (ibr_in && ibr_link_in && !(reg_wr_in && reg_addr_in == erx_pkg::ADR_LR)) |=>
      (s.lr == $past(next_pc_in)) && s.redir;
  endproperty
  a_link: assert property (p_link) else $error("link not written");

  property p_save_machine_state_ri;
    (s.st == erx_pkg::ERX_DRAIN && !busy_in) |=>
      s.save_machine_state[erx_pkg::MSR_RI] == $past(s.machine_state_reg[erx_pkg::MSR_RI]);
  endproperty
  a_save_machine_state_ri: assert property (p_save_machine_state_ri) else $error("recoverable not captured");

  property p_entry_clear;
    (s.st == erx_pkg::ERX_DRAIN && !busy_in) |=>
      !s.machine_state_reg[erx_pkg::MSR_RI] && !s.machine_state_reg[erx_pkg::MSR_FP];
  endproperty
  a_entry_clear: assert property (p_entry_clear) else $error("state not modified");

  property p_ext_vec;
    (s.st == erx_pkg::ERX_RUN && ext_pend && !dbg_hit && !sync_exc_in) |=>
      s.cause == erx_pkg::VEC_EXT;
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

  property p_sync_vec;
    (s.st == erx_pkg::ERX_RUN && sync_exc_in && !dbg_hit) |=>
      s.cause == $past(sync_vec_in);
  endproperty
  a_sync_vec: assert property (p_sync_vec) else $error("sync vector wrong");

  property p_code_main;
    (|masked[erx_pkg::MAIN_LVL-1:0]) |->
      code < 8'(erx_pkg::MAIN_LVL);
  endproperty
  a_code_main: assert property (p_code_main) else $error("level priority wrong");

  property p_code_seven;
    (masked[erx_pkg::MAIN_LVL-1:0] == '0 && |masked[erx_pkg::NLVL-1:erx_pkg::MAIN_LVL]) |->
      code == 8'(erx_pkg::MAIN_LVL);
  endproperty
  a_code_seven: assert property (p_code_seven) else $error("level 7 report wrong");

  property p_code_none;
    (masked == erx_pkg::ZERO16) |->
      code == erx_pkg::CODE_NONE;
  endproperty
  a_code_none: assert property (p_code_none) else $error("empty code wrong");

  property p_pend_low;
    1'b1 |->
      pend[erx_pkg::PEND_TOP-erx_pkg::NLVL:0] == erx_pkg::ZERO16;
  endproperty
  a_pend_low: assert property (p_pend_low) else $error("pending low half set");

  property p_rdata_idle;
    !reg_rd_in |=>
      s.rdata == erx_pkg::ZERO32;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_rd_msr;
    (reg_rd_in && reg_addr_in == erx_pkg::ADR_MSR) |=>
      s.rdata == $past(s.machine_state_reg);
  endproperty
  a_rd_msr: assert property (p_rd_msr) else $error("state read wrong");

  property p_ctr_target;
    (ibr_in && ibr_ctr_in && !rfi_in && !(s.st == erx_pkg::ERX_DRAIN && !busy_in)) |=>
      s.raddr == $past(s.ctr);
  endproperty
  a_ctr_target: assert property (p_ctr_target) else $error("count target wrong");

endmodule : erx_exc_unit

// *** tb/erx_src_model.sv ***
// Purpose: far-side interrupt sources feeding the level inputs
// Assumes: same clock as the core
// Notes: a level stays up until cleared, as a real peripheral does
`timescale 1ns/1ps
module erx_src_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // bench control
  input wire logic [15:0] raise_in,
  input wire logic [15:0] clear_in,
  // request levels
  output logic [15:0] lvl_req_out
);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lvl_req_out <= 16'h0000;
    end else begin
      lvl_req_out <= (lvl_req_out | raise_in) & ~clear_in;
    end
  end
endmodule : erx_src_model

// *** tb/test_exception_entry_return.sv ***
// Purpose: self-checking bench for the exception unit
// Assumes: one clock, far-side levels from erx_src_model
// Notes: expectations come from a small state model kept in the bench
`timescale 1ns/1ps
module test_exception_entry_return;
  logic clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, busy = 0, sx = 0, rfi = 0;
  logic ib = 0, ic = 0, il = 0, bp = 0, rdr, tk, rf;
  logic [3:0] a = 4'h0;
  logic [15:0] up = 16'h0000, dn = 16'h0000, lv;
  logic [31:0] wd = 0, pc = 0, sv = 0, rdat, radr, machine_state_reg, ra, ms, r, m, s1, t0, t1;
  logic [31:0] x = 32'h0000_f265;
  int miscompares = 0, cmp_count = 0, cyc = 0, k;
  erx_exc_unit erx_exc_unit_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .busy_in(busy), .next_pc_in(pc), .sync_exc_in(sx),
    .sync_vec_in(sv), .rfi_in(rfi), .ibr_in(ib), .ibr_ctr_in(ic), .ibr_link_in(il),
    .redirect_out(rdr), .redirect_addr_out(radr), .taken_out(tk), .msr_out(machine_state_reg),
    .bp_in(bp), .lvl_req_in(lv));
  erx_src_model erx_src_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .raise_in(up), .clear_in(dn), .lvl_req_out(lv));
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 4000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task acc(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    wr <= 0;
    rd <= 0;
    #1 r = rdat;
  endtask : acc
  // one-cycle strobes drop at the edge that samples them; stops at the first redirect
  task wt(input int lim);
    k = -1;
    for (int i = 0; i < lim && k < 0; i++) begin
      @(posedge clk_in);
      ib <= 0;
      rfi <= 0;
      sx <= 0;
      up <= 16'h0000;
      dn <= 16'h0000;
      #1;
      if (rdr === 1'b1) begin
        k = i;
        ra = radr;
        ms = machine_state_reg;
        rf = tk;
      end
    end
  endtask : wt
  task pul(input logic c, input logic l, input logic f);
    @(posedge clk_in);
    ib <= !f;
    ic <= c;
    il <= l;
    rfi <= f;
    wt(1);
    chk("redirect", 32'h0000_0000, k);
  endtask : pul
  task go(input logic [31:0] v);
    wt(4);
    bp <= 0;
    s1 = {16'h0000, m[15:0]};
    m = m & 32'hffff_5ffd;
    chk("vector", v, ra);
    chk("taken", 32'h0000_0001, rf);
    chk("msr entry", m, ms);
    acc(0, erx_pkg::ADR_SAVE_RET, 0);
    chk("save_return_address", pc, r);
    acc(0, erx_pkg::ADR_SAVE_MS, 0);
    chk("save_machine_state", s1, r);
  endtask : go
  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1;
    acc(0, erx_pkg::ADR_MSR, 0);
    chk("msr reset", erx_pkg::MSR_RST, r);
    acc(0, 4'hB, 0);
    chk("unmapped", 32'h0000_0000, r);
    t0 = rnd();
    acc(1, erx_pkg::ADR_CTR, t0);
    t1 = rnd();
    acc(1, erx_pkg::ADR_LR, t1);
    pc <= rnd();
    pul(1, 0, 0);
    chk("ctr target", t0, ra);
    pul(0, 1, 0);
    chk("lr target", t1, ra);
    acc(0, erx_pkg::ADR_LR, 0);
    chk("link", pc, r);
    bp <= 1;
    wt(4);
    chk("masked bp", 32'hffff_ffff, k);
    acc(1, erx_pkg::ADR_RSET, rnd());
    m = 32'h0000_0002;
    chk("rset", m, machine_state_reg);
    go(erx_pkg::VEC_DBG);
    @(posedge clk_in);
    busy <= 1;
    sx <= 1;
    sv <= rnd() & 32'h0000_0ff0;
    pc <= rnd();
    wt(4);
    chk("early", 32'hffff_ffff, k);
    busy <= 0;
    go(erx_pkg::VEC_BASE + sv);
    acc(1, erx_pkg::ADR_DBG, 32'h0000_0001);
    pc <= rnd();
    bp <= 1;
    go(erx_pkg::VEC_DBG);
    m = rnd() & 32'hffff_7ffd;
    acc(1, erx_pkg::ADR_MSR, m);
    acc(1, erx_pkg::ADR_SAVE_RET, t0);
    t1 = rnd() & 32'h0000_7fff;
    acc(1, erx_pkg::ADR_SAVE_MS, t1);
    pul(0, 0, 1);
    m[15:0] = t1[15:0];
    chk("rfi target", t0, ra);
    chk("rfi msr", m, ms);
    acc(1, erx_pkg::ADR_LMASK, 32'h0000_ffff);
    @(posedge clk_in);
    up <= 16'h0208;
    wt(1);
    acc(0, erx_pkg::ADR_IVEC, 0);
    chk("code", 32'h0000_0003, r);
    acc(0, erx_pkg::ADR_PEND, 0);
    chk("pending", 32'h0040_0000, r);
    @(posedge clk_in);
    dn <= 16'h0008;
    wt(1);
    acc(0, erx_pkg::ADR_IVEC, 0);
    chk("code 7", 32'h0000_0007, r);
    acc(1, erx_pkg::ADR_ERSET, 0);
    m = m | 32'h0000_8002;
    chk("erset", m, machine_state_reg);
    go(erx_pkg::VEC_EXT);
    test_done();
  end
endmodule : test_exception_entry_return
